// >>> verilog/itc_consts.vh
/*
 * Constants for the ignition timing control block: register indices,
 * field positions, reset values, widths and fault codes.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef ITC_CONSTS_VH
`define ITC_CONSTS_VH

// Register indices (word addresses on the plain register port)
`define ITC_R_CTRL      6'h00
`define ITC_R_STATUS    6'h01
`define ITC_R_KEY       6'h02
`define ITC_R_POTA_CCW  6'h03
`define ITC_R_POTA_CW   6'h04
`define ITC_R_POTB_CCW  6'h05
`define ITC_R_POTB_CW   6'h06
`define ITC_R_MA_LO     6'h07
`define ITC_R_MA_HI     6'h08
`define ITC_R_MA_DEF    6'h09
`define ITC_R_V_LO      6'h0a
`define ITC_R_V_HI      6'h0b
`define ITC_R_ADV_MAX   6'h0c
`define ITC_R_RET_MAX   6'h0d
`define ITC_R_CAN_TIM   6'h0e
`define ITC_R_RESET_POS 6'h0f
`define ITC_R_TEETH     6'h10
`define ITC_R_SPEED     6'h11
`define ITC_R_ANGLE     6'h12
`define ITC_R_TIMING    6'h13
`define ITC_R_SPD_BP    6'h18
`define ITC_R_SPD_OF    6'h21
`define ITC_R_SEL_A     6'h1e
`define ITC_R_SEL_B     6'h1f
`define ITC_R_CLR_FLT   6'h20

// Control register fields
`define ITC_C_FOUR      0
`define ITC_C_SCHB_EN   1
`define ITC_C_CAN       2
`define ITC_C_RUN       3

// Schedule contribution select fields
`define ITC_S_MA        0
`define ITC_S_V         1
`define ITC_S_SPD       2

// Widths and counts
`define ITC_DW          16
`define ITC_NBP         5
`define ITC_KEY_VAL     16'h5a3c
`define ITC_CTRL_RST    16'h0001
`define ITC_SEL_RST     16'h0007
`define ITC_TEETH_RST   16'h0078
`define ITC_ADV_RST     16'h0190
`define ITC_RET_RST     16'hff38
`define ITC_SPD_WIN     16'h61a8
`define ITC_FRAC_SH     8
`define ITC_MA_LOW      12'h199
`define ITC_MA_SPAN     12'h666
`define ITC_MA_LOST     12'h0cc

// Fault codes
`define ITC_F_NONE      3'h0
`define ITC_F_EXTRA     3'h1
`define ITC_F_MISSING   3'h2
`define ITC_F_CAM       3'h3
`define ITC_F_RESET2    3'h4

`endif

// >>> verilog/itc_lerp.v
/*
 * Linear interpolation between two signed end values by an unsigned
 * fraction, registered output.
 * Assumes one clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
`include "itc_consts.vh"

module itc_lerp (
	// Clock and reset
	input  wire        clk_in,
	input  wire        rst_n_in,
	// Operands
	input  wire [15:0] lo_in,
	input  wire [15:0] hi_in,
	input  wire [11:0] frac_in,
	input  wire [11:0] span_in,
	// Result
	output reg  [15:0] val_out
);
	wire signed [16:0] diff;
	wire signed [29:0] prod;
	wire signed [29:0] quot;

	// lo + (hi-lo)*frac/span
	assign diff = $signed({hi_in[15], hi_in}) - $signed({lo_in[15], lo_in});
	assign prod = diff * $signed({1'b0, frac_in});
	assign quot = (span_in == 12'h000) ? 30'sh0 : prod / $signed({18'h0, span_in});

	// Registered result
	always @(posedge clk_in) begin
		if (!rst_n_in) begin
			val_out <= 16'h0000;
		end else begin
			val_out <= lo_in + quot[15:0];
		end
	end
endmodule // itc_lerp

`default_nettype wire

// >>> verilog/itc_core.v
/*
 * Crank position tracking and spark timing computation.
 * Assumes sensor pulses synchronous to the 25 MHz clock and a plain
 * register port with read data one cycle after the read strobe.
 */
// Operation
// [RULE1] Two pickups for two-stroke, third cam pickup for four-stroke.
// [RULE2] Trigger teeth give both engine speed and crank position.
// [RULE3] Erroneous sensor pulse pattern shuts ignition down.
// [RULE4] One reset index per revolution; tooth counting starts there.
// [RULE5] Installer sets index 20-120 degrees advanced and programs it.
// [RULE6] Index at least 10 degrees beyond most advanced timing.
// [RULE7] Four-stroke cam event each 720 degrees picks revolution.
// [RULE8] Cam event 20-50 degrees ahead of index, cylinder one.
// [RULE9] CAN timing mode ignores current loop and knob terms.
// [RULE10] Knob A unless contact grounded and schedule B enabled.
// [RULE11] Each knob span set by CCW and CW timing values.
// [RULE12] Knob span writes need a valid password first.
// [RULE13] Summed timing clamped to max advance and max retard.
// [RULE14] Knob timing is in degrees relative to top dead centre.
// [RULE15] Current-loop offset interpolated between 4 and 20 mA values.
// [RULE16] Lost current loop uses programmed default offset.
// [RULE17] Voltage offset interpolated between 0 V and 5 V values.
// [RULE18] Speed offset follows up to five-breakpoint linear curve.
// [RULE19] Contact selects schedule; each schedule picks its own terms.
// [RULE20] Angle from teeth since index; phase from last cam event.
`timescale 1ns/1ps
`default_nettype none
`include "itc_consts.vh"

module itc_core (
	// Clock and reset
	input  wire        CORE_CLK_IN,
	input  wire        RST_N_IN,
	// Magnetic pickup sensor pulses
	input  wire        TRIG_PULSE_IN,
	input  wire        INDEX_PULSE_IN,
	input  wire        CAM_PULSE_IN,
	// Analog values, already digitised, and schedule B contact
	input  wire [11:0] POT_A_IN,
	input  wire [11:0] POT_B_IN,
	input  wire [11:0] MA_LOOP_IN,
	input  wire [11:0] VOLT_IN,
	input  wire        SCHED_B_GND_IN,
	// Register port
	input  wire [5:0]  REG_ADDR_IN,
	input  wire [15:0] REG_WDATA_IN,
	input  wire        REG_WR_IN,
	input  wire        REG_RD_IN,
	output reg  [15:0] REG_RDATA_OUT,
	// Results
	output reg  [15:0] TIMING_OUT,
	output reg  [15:0] ANGLE_OUT,
	output reg         SECOND_REV_OUT,
	output reg         SHUTDOWN_OUT
);
	localparam ST_SYNC = 3'b001;
	localparam ST_RUN  = 3'b010;
	localparam ST_TRIP = 3'b100;

	reg [15:0] ctrl_q, sel_a_q, sel_b_q, pa_ccw_q, pa_cw_q, pb_ccw_q, pb_cw_q;
	reg [15:0] ma_lo_q, ma_hi_q, ma_def_q, v_lo_q, v_hi_q, adv_q, ret_q;
	reg [15:0] can_q, rpos_q, teeth_q;
	reg [15:0] bp_q [0:`ITC_NBP-1];
	reg [15:0] of_q [0:`ITC_NBP-1];
	reg        unlock_q;
	reg [2:0]  state_q, fault_q;
	reg [15:0] tooth_q, win_q, tcnt_q, speed_q;
	reg        phase_q, cam_seen_q;
	reg [15:0] rdata_d;
	reg [15:0] spd_off_d;
	reg [15:0] sum_d;
	reg        wr_fault_d;
	reg [2:0]  fault_d;
	integer    i, j, k;

	wire four = ctrl_q[`ITC_C_FOUR];
	wire can_mode = ctrl_q[`ITC_C_CAN];
	wire sched_b = SCHED_B_GND_IN & ctrl_q[`ITC_C_SCHB_EN]; // RULE10
	wire [15:0] sel = sched_b ? sel_b_q : sel_a_q;         // RULE19
	wire ma_lost = MA_LOOP_IN < `ITC_MA_LOST;
	wire [11:0] ma_frac = (MA_LOOP_IN > `ITC_MA_LOW) ? MA_LOOP_IN - `ITC_MA_LOW : 12'h000;
	wire [15:0] pot_val, ma_val, v_val;
	wire w_key = REG_WR_IN & (REG_ADDR_IN == `ITC_R_KEY);

	// Span address decode, used by the write side only
	function is_span;
		input [5:0] a;
		begin
			is_span = (a == `ITC_R_POTA_CCW) | (a == `ITC_R_POTA_CW) |
				(a == `ITC_R_POTB_CCW) | (a == `ITC_R_POTB_CW);
		end
	endfunction

	// Knob lerp, CCW to CW, degrees from top dead centre
	itc_lerp u_pot (
		.clk_in   (CORE_CLK_IN),
		.rst_n_in (RST_N_IN),
		.lo_in    (sched_b ? pb_ccw_q : pa_ccw_q), // RULE11 RULE14
		.hi_in    (sched_b ? pb_cw_q : pa_cw_q),
		.frac_in  (sched_b ? POT_B_IN : POT_A_IN),
		.span_in  (12'hfff),
		.val_out  (pot_val)
	);
	// Current loop lerp, 4 to 20 mA
	itc_lerp u_ma (
		.clk_in   (CORE_CLK_IN),
		.rst_n_in (RST_N_IN),
		.lo_in    (ma_lo_q), // RULE15
		.hi_in    (ma_hi_q),
		.frac_in  ((ma_frac > `ITC_MA_SPAN) ? `ITC_MA_SPAN : ma_frac),
		.span_in  (`ITC_MA_SPAN),
		.val_out  (ma_val)
	);
	// Voltage lerp, 0 to 5 V
	itc_lerp u_v (
		.clk_in   (CORE_CLK_IN),
		.rst_n_in (RST_N_IN),
		.lo_in    (v_lo_q), // RULE17
		.hi_in    (v_hi_q),
		.frac_in  (VOLT_IN),
		.span_in  (12'hfff),
		.val_out  (v_val)
	);

	// Register writes; span limits locked until key written
	always @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			ctrl_q <= `ITC_CTRL_RST; sel_a_q <= `ITC_SEL_RST; sel_b_q <= 16'h0000;
			pa_ccw_q <= 16'h0000; pa_cw_q <= 16'h0000;
			pb_ccw_q <= 16'h0000; pb_cw_q <= 16'h0000;
			ma_lo_q <= 16'h0000; ma_hi_q <= 16'h0000; ma_def_q <= 16'h0000;
			v_lo_q <= 16'h0000; v_hi_q <= 16'h0000;
			adv_q <= `ITC_ADV_RST; ret_q <= `ITC_RET_RST;
			can_q <= 16'h0000; rpos_q <= 16'h0000; teeth_q <= `ITC_TEETH_RST;
			unlock_q <= 1'b0;
			for (i = 0; i < `ITC_NBP; i = i + 1) begin
				bp_q[i] <= 16'h0000;
				of_q[i] <= 16'h0000;
			end
		end else if (REG_WR_IN) begin
			if (w_key)
				unlock_q <= (REG_WDATA_IN == `ITC_KEY_VAL); // RULE12
			if (is_span(REG_ADDR_IN) && unlock_q) begin // RULE12
				case (REG_ADDR_IN)
					`ITC_R_POTA_CCW: pa_ccw_q <= REG_WDATA_IN;
					`ITC_R_POTA_CW:  pa_cw_q  <= REG_WDATA_IN;
					`ITC_R_POTB_CCW: pb_ccw_q <= REG_WDATA_IN;
					default:         pb_cw_q  <= REG_WDATA_IN;
				endcase
			end
			case (REG_ADDR_IN)
				`ITC_R_CTRL:      ctrl_q   <= REG_WDATA_IN;
				`ITC_R_SEL_A:     sel_a_q  <= REG_WDATA_IN;
				`ITC_R_SEL_B:     sel_b_q  <= REG_WDATA_IN;
				`ITC_R_MA_LO:     ma_lo_q  <= REG_WDATA_IN;
				`ITC_R_MA_HI:     ma_hi_q  <= REG_WDATA_IN;
				`ITC_R_MA_DEF:    ma_def_q <= REG_WDATA_IN;
				`ITC_R_V_LO:      v_lo_q   <= REG_WDATA_IN;
				`ITC_R_V_HI:      v_hi_q   <= REG_WDATA_IN;
				`ITC_R_ADV_MAX:   adv_q    <= REG_WDATA_IN;
				`ITC_R_RET_MAX:   ret_q    <= REG_WDATA_IN;
				`ITC_R_CAN_TIM:   can_q    <= REG_WDATA_IN;
				`ITC_R_RESET_POS: rpos_q   <= REG_WDATA_IN; // RULE5
				`ITC_R_TEETH:     teeth_q  <= REG_WDATA_IN;
				default: begin
					for (i = 0; i < `ITC_NBP; i = i + 1) begin
						if (REG_ADDR_IN == `ITC_R_SPD_BP + i[5:0])
							bp_q[i] <= REG_WDATA_IN;
						if (REG_ADDR_IN == `ITC_R_SPD_OF + i[5:0])
							of_q[i] <= REG_WDATA_IN;
					end
				end
			endcase
		end
	end

	// Read mux; unmapped reads zero, span limits read back always
	always @* begin
		rdata_d = 16'h0000;
		case (REG_ADDR_IN)
			`ITC_R_CTRL:      rdata_d = ctrl_q;
			`ITC_R_STATUS:    rdata_d = {8'h00, unlock_q, phase_q, state_q[1], SHUTDOWN_OUT,
				1'b0, fault_q};
			`ITC_R_POTA_CCW:  rdata_d = pa_ccw_q;
			`ITC_R_POTA_CW:   rdata_d = pa_cw_q;
			`ITC_R_POTB_CCW:  rdata_d = pb_ccw_q;
			`ITC_R_POTB_CW:   rdata_d = pb_cw_q;
			`ITC_R_MA_LO:     rdata_d = ma_lo_q;
			`ITC_R_MA_HI:     rdata_d = ma_hi_q;
			`ITC_R_MA_DEF:    rdata_d = ma_def_q;
			`ITC_R_V_LO:      rdata_d = v_lo_q;
			`ITC_R_V_HI:      rdata_d = v_hi_q;
			`ITC_R_ADV_MAX:   rdata_d = adv_q;
			`ITC_R_RET_MAX:   rdata_d = ret_q;
			`ITC_R_CAN_TIM:   rdata_d = can_q;
			`ITC_R_RESET_POS: rdata_d = rpos_q;
			`ITC_R_TEETH:     rdata_d = teeth_q;
			`ITC_R_SPEED:     rdata_d = speed_q;
			`ITC_R_ANGLE:     rdata_d = ANGLE_OUT;
			`ITC_R_TIMING:    rdata_d = TIMING_OUT;
			`ITC_R_SEL_A:     rdata_d = sel_a_q;
			`ITC_R_SEL_B:     rdata_d = sel_b_q;
			default: begin
				for (j = 0; j < `ITC_NBP; j = j + 1) begin
					if (REG_ADDR_IN == `ITC_R_SPD_BP + j[5:0])
						rdata_d = bp_q[j];
					if (REG_ADDR_IN == `ITC_R_SPD_OF + j[5:0])
						rdata_d = of_q[j];
				end
			end
		endcase
	end

	always @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN)
			REG_RDATA_OUT <= 16'h0000;
		else if (REG_RD_IN)
			REG_RDATA_OUT <= rdata_d;
		else
			REG_RDATA_OUT <= 16'h0000;
	end

	// Sensor pattern checks feeding the trip
	always @* begin
		fault_d = `ITC_F_NONE;
		wr_fault_d = 1'b0;
		if (state_q == ST_RUN) begin
			if (TRIG_PULSE_IN && tooth_q >= teeth_q - 16'h0001 && !INDEX_PULSE_IN)
				fault_d = `ITC_F_EXTRA; // RULE3
			else if (INDEX_PULSE_IN && tooth_q != teeth_q - 16'h0001 && !TRIG_PULSE_IN)
				fault_d = `ITC_F_MISSING; // RULE3
			else if (INDEX_PULSE_IN && four && phase_q != cam_seen_q) // Cam must alternate
				fault_d = `ITC_F_CAM; // RULE3 RULE7
		end
		wr_fault_d = (fault_d != `ITC_F_NONE);
	end

	// Tooth counting from index, cam phase, trip state
	always @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			state_q <= ST_SYNC; fault_q <= `ITC_F_NONE;
			tooth_q <= 16'h0000; phase_q <= 1'b0; cam_seen_q <= 1'b0;
		end else begin
			if (TRIG_PULSE_IN)
				tooth_q <= tooth_q + 16'h0001; // RULE2 RULE20
			if (CAM_PULSE_IN && four)
				cam_seen_q <= 1'b1; // RULE1 RULE8
			if (INDEX_PULSE_IN) begin
				tooth_q <= 16'h0000; // RULE4 RULE20
				phase_q <= (four && !cam_seen_q) ? ~phase_q : 1'b0; // RULE7
				if (cam_seen_q)
					phase_q <= 1'b0;
				cam_seen_q <= 1'b0;
			end
			case (state_q)
				ST_SYNC: if (INDEX_PULSE_IN && ctrl_q[`ITC_C_RUN] && (!four || cam_seen_q))
					state_q <= ST_RUN; // RULE7
				ST_RUN: if (wr_fault_d) begin
					state_q <= ST_TRIP; // RULE3
					fault_q <= fault_d;
				end else if (!ctrl_q[`ITC_C_RUN])
					state_q <= ST_SYNC;
				ST_TRIP: if (REG_WR_IN && REG_ADDR_IN == `ITC_R_CLR_FLT) begin
					state_q <= ST_SYNC;
					fault_q <= `ITC_F_NONE;
				end
				default: state_q <= ST_SYNC;
			endcase
		end
	end

	// Speed as teeth per fixed window
	always @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			win_q <= 16'h0000; tcnt_q <= 16'h0000; speed_q <= 16'h0000;
		end else if (win_q == `ITC_SPD_WIN - 16'h0001) begin
			win_q <= 16'h0000;
			speed_q <= tcnt_q + {15'h0, TRIG_PULSE_IN}; // RULE2
			tcnt_q <= 16'h0000;
		end else begin
			win_q <= win_q + 16'h0001;
			tcnt_q <= tcnt_q + {15'h0, TRIG_PULSE_IN};
		end
	end

	// Speed curve, piecewise between breakpoints
	always @* begin
		spd_off_d = of_q[0];
		for (k = 1; k < `ITC_NBP; k = k + 1) begin
			if (speed_q >= bp_q[k]) spd_off_d = of_q[k]; // RULE18
			else if (speed_q > bp_q[k-1] && bp_q[k] != bp_q[k-1])
				spd_off_d = of_q[k-1] + (((of_q[k] - of_q[k-1]) * (speed_q - bp_q[k-1])) /
					(bp_q[k] - bp_q[k-1]));
		end
	end

	// Sum of selected terms; CAN drops knob and loop terms
	always @* begin
		if (can_mode)
			sum_d = can_q; // RULE9
		else
			sum_d = pot_val +
				(sel[`ITC_S_MA] ? (ma_lost ? ma_def_q : ma_val) : 16'h0000); // RULE15 RULE16
		sum_d = sum_d + (sel[`ITC_S_V] ? v_val : 16'h0000) // RULE17 RULE19
			+ (sel[`ITC_S_SPD] ? spd_off_d : 16'h0000);   // RULE18
	end

	// Clamped timing and position outputs
	always @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			TIMING_OUT <= 16'h0000; ANGLE_OUT <= 16'h0000;
			SECOND_REV_OUT <= 1'b0; SHUTDOWN_OUT <= 1'b1;
		end else begin
			if ($signed(sum_d) > $signed(adv_q)) TIMING_OUT <= adv_q; // RULE13
			else if ($signed(sum_d) < $signed(ret_q)) TIMING_OUT <= ret_q; // RULE13
			else TIMING_OUT <= sum_d;
			ANGLE_OUT <= tooth_q; // RULE20
			SECOND_REV_OUT <= phase_q; // RULE7
			SHUTDOWN_OUT <= (state_q != ST_RUN); // RULE3
		end
	end
endmodule // itc_core

`default_nettype wire

// >>> bench/itc_core_props.sv
/* Port assertions for the ignition timing core.
 * Assumes binding onto itc_core, one clock, synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
`include "itc_consts.vh"
module itc_core_props (
	// Clock and reset
	input wire logic        CORE_CLK_IN,
	input wire logic        RST_N_IN,
	// Pickup pulses
	input wire logic        TRIG_PULSE_IN,
	input wire logic        INDEX_PULSE_IN,
	input wire logic        CAM_PULSE_IN,
	// Analog values and contact
	input wire logic [11:0] POT_A_IN,
	input wire logic [11:0] POT_B_IN,
	input wire logic [11:0] MA_LOOP_IN,
	input wire logic [11:0] VOLT_IN,
	input wire logic        SCHED_B_GND_IN,
	// Register port
	input wire logic [5:0]  REG_ADDR_IN,
	input wire logic [15:0] REG_WDATA_IN,
	input wire logic        REG_WR_IN,
	input wire logic        REG_RD_IN,
	input wire logic [15:0] REG_RDATA_OUT,
	// Results
	input wire logic [15:0] TIMING_OUT,
	input wire logic [15:0] ANGLE_OUT,
	input wire logic        SECOND_REV_OUT,
	input wire logic        SHUTDOWN_OUT
);
	default clocking @(posedge CORE_CLK_IN); endclocking
	default disable iff (!RST_N_IN);
	logic [15:0] adv_q;
	logic [15:0] ret_q;
	// Shadow copies of the clamp limits
	always @(posedge CORE_CLK_IN) begin
		if (!RST_N_IN) begin
			adv_q <= `ITC_ADV_RST;
			ret_q <= `ITC_RET_RST;
		end else if (REG_WR_IN && REG_ADDR_IN == `ITC_R_ADV_MAX) begin
			adv_q <= REG_WDATA_IN;
		end else if (REG_WR_IN && REG_ADDR_IN == `ITC_R_RET_MAX) begin
			ret_q <= REG_WDATA_IN;
		end
	end
	property p_reset_out;
		$rose(RST_N_IN) |-> SHUTDOWN_OUT && ANGLE_OUT == 16'h0000;
	endproperty
	a_reset_out: assert property (p_reset_out) else $error("outputs wrong at reset");
	property p_status_trip;
		REG_RD_IN && REG_ADDR_IN == `ITC_R_STATUS |=> REG_RDATA_OUT[4] == $past(SHUTDOWN_OUT);
	endproperty
	a_status_trip: assert property (p_status_trip) else $error("status trip bit wrong");
	property p_hold_trip;
		SHUTDOWN_OUT && !$past(INDEX_PULSE_IN) && !REG_WR_IN |=> SHUTDOWN_OUT;
	endproperty
	a_hold_trip: assert property (p_hold_trip) else $error("shutdown dropped early");
	property p_leave_trip;
		$fell(SHUTDOWN_OUT) |-> $past(INDEX_PULSE_IN, 2) || $past(INDEX_PULSE_IN, 3)
			|| $past(REG_WR_IN) || $past(REG_WR_IN, 2);
	endproperty
	a_leave_trip: assert property (p_leave_trip) else $error("shutdown left with no cause");
	property p_clamp;
		adv_q == $past(adv_q, 3) && ret_q == $past(ret_q, 3) |->
			$signed(TIMING_OUT) <= $signed(adv_q) && $signed(TIMING_OUT) >= $signed(ret_q);
	endproperty
	a_clamp: assert property (p_clamp) else $error("timing outside limits");
	property p_index_zero;
		INDEX_PULSE_IN && !TRIG_PULSE_IN && !SHUTDOWN_OUT ##1 !TRIG_PULSE_IN && !INDEX_PULSE_IN
			|=> ANGLE_OUT == 16'h0000;
	endproperty
	a_index_zero: assert property (p_index_zero) else $error("index did not restart angle");
	sequence s_one_tooth;
		!TRIG_PULSE_IN && !INDEX_PULSE_IN && !SHUTDOWN_OUT ##1 TRIG_PULSE_IN && !INDEX_PULSE_IN
			##1 !TRIG_PULSE_IN && !INDEX_PULSE_IN;
	endsequence
	property p_tooth_step;
		s_one_tooth |=> ANGLE_OUT == $past(ANGLE_OUT) + 16'h0001;
	endproperty
	a_tooth_step: assert property (p_tooth_step) else $error("tooth did not step angle");
	property p_phase;
		$changed(SECOND_REV_OUT) |-> $past(INDEX_PULSE_IN) || $past(INDEX_PULSE_IN, 2)
			|| $past(INDEX_PULSE_IN, 3) || $past(REG_WR_IN);
	endproperty
	a_phase: assert property (p_phase) else $error("phase moved away from index");
	c_trip: cover property ($rose(SHUTDOWN_OUT));
	c_phase: cover property ($changed(SECOND_REV_OUT));
	c_clamped: cover property (TIMING_OUT == adv_q);
endmodule // itc_core_props
bind itc_core itc_core_props u_props (.CORE_CLK_IN, .RST_N_IN, .TRIG_PULSE_IN, .INDEX_PULSE_IN,
	.CAM_PULSE_IN, .POT_A_IN, .POT_B_IN, .MA_LOOP_IN, .VOLT_IN, .SCHED_B_GND_IN, .REG_ADDR_IN,
	.REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .TIMING_OUT, .ANGLE_OUT,
	.SECOND_REV_OUT, .SHUTDOWN_OUT);
`default_nettype wire

// >>> bench/itc_sensor_model.sv
/* Behavioural trigger, index and cam pickups for the timing core.
 * Assumes the bench drives its controls just after rising edges. */
`timescale 1ns/1ps
`default_nettype none
module itc_sensor_model #(
	parameter int GAP = 6
) (
	// Clock and reset
	input  wire logic        clk_in,
	input  wire logic        rst_n_in,
	// Controls from the bench
	input  wire logic        run_in,
	input  wire logic        extra_in,
	input  wire logic [15:0] teeth_in,
	// Pickup pulses, three sensors for four-stroke
	output logic             trig_out,
	output logic             index_out,
	output logic             cam_out
);
	int unsigned gap_q;
	int unsigned slot_q;
	logic        rev_q;
	// One slot per tooth; slot zero carries the index mark
	always @(posedge clk_in) begin
		trig_out <= 1'b0;
		index_out <= 1'b0;
		cam_out <= 1'b0;
		if (!rst_n_in || !run_in) begin
			gap_q <= 0;
			slot_q <= 0;
			rev_q <= 1'b0;
		end else begin
			gap_q <= (gap_q == GAP - 1) ? 0 : gap_q + 1;
			if (gap_q == GAP - 1) begin
				slot_q <= (slot_q == teeth_in - 1) ? 0 : slot_q + 1;
			end
			if (gap_q == GAP - 1 && slot_q == teeth_in - 1) begin
				rev_q <= !rev_q;
			end
			// Index once a turn, well ahead of any commanded spark
			if (gap_q == 0 && slot_q == 0) begin
				index_out <= 1'b1;
			end
			if (gap_q == 0 && slot_q != 0) begin
				trig_out <= 1'b1;
			end
			// Cam mark every other turn, shortly ahead of the index
			if (gap_q == GAP / 2 && slot_q == teeth_in - 1 && rev_q) begin
				cam_out <= 1'b1;
			end
			// Bracket chatter, only when the bench asks
			if (gap_q == GAP / 2 && slot_q == 2 && extra_in) begin
				trig_out <= 1'b1;
			end
		end
	end
endmodule // itc_sensor_model
`default_nettype wire

// >>> bench/test_ignition_timing_control.sv
/* Self-checking bench for the ignition timing core.
 * Assumes the core, its constants header and the pickup model. */
`timescale 1ns/1ps
`default_nettype none
`include "itc_consts.vh"
`define ITC_CHK(got, exp) begin \
	compares++; \
	if ((got) !== (exp)) begin \
		bad_count++; \
		$display("[ERR] %0t mismatch got %h exp %h", $time, got, exp); \
	end \
end
module test_ignition_timing_control;
	localparam int GAP = 6;
	logic        CORE_CLK_IN, RST_N_IN, TRIG_PULSE_IN, INDEX_PULSE_IN, CAM_PULSE_IN;
	logic [11:0] POT_A_IN, POT_B_IN, MA_LOOP_IN, VOLT_IN;
	logic        SCHED_B_GND_IN, REG_WR_IN, REG_RD_IN, SECOND_REV_OUT, SHUTDOWN_OUT;
	logic [5:0]  REG_ADDR_IN;
	logic [15:0] REG_WDATA_IN, REG_RDATA_OUT, TIMING_OUT, ANGLE_OUT;
	logic        eng_run, eng_extra;
	logic        top_seen = 1'b0;
	logic        phase_seen = 1'b0;
	int          bad_count, compares, cycles;
	itc_core DUT (.CORE_CLK_IN, .RST_N_IN, .TRIG_PULSE_IN, .INDEX_PULSE_IN, .CAM_PULSE_IN,
		.POT_A_IN, .POT_B_IN, .MA_LOOP_IN, .VOLT_IN, .SCHED_B_GND_IN, .REG_ADDR_IN,
		.REG_WDATA_IN, .REG_WR_IN, .REG_RD_IN, .REG_RDATA_OUT, .TIMING_OUT, .ANGLE_OUT,
		.SECOND_REV_OUT, .SHUTDOWN_OUT);
	itc_sensor_model #(.GAP(GAP)) u_eng (.clk_in(CORE_CLK_IN), .rst_n_in(RST_N_IN),
		.run_in(eng_run), .extra_in(eng_extra), .teeth_in(16'h0008),
		.trig_out(TRIG_PULSE_IN), .index_out(INDEX_PULSE_IN), .cam_out(CAM_PULSE_IN));
	// Register port cycles and settled result checks
	task automatic wr(input logic [5:0] a, input logic [15:0] d);
		@(posedge CORE_CLK_IN);
		REG_ADDR_IN <= a;
		REG_WDATA_IN <= d;
		REG_WR_IN <= 1'b1;
		@(posedge CORE_CLK_IN);
		REG_WR_IN <= 1'b0;
	endtask
	task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
		@(posedge CORE_CLK_IN);
		REG_ADDR_IN <= a;
		REG_RD_IN <= 1'b1;
		@(posedge CORE_CLK_IN);
		REG_RD_IN <= 1'b0;
		#1;
		`ITC_CHK(REG_RDATA_OUT, e)
	endtask
	task automatic tim_chk(input logic [15:0] e);
		repeat (4) @(posedge CORE_CLK_IN);
		#1;
		`ITC_CHK(TIMING_OUT, e)
	endtask
	task automatic revs(input int n);
		repeat (n * 8 * GAP) @(posedge CORE_CLK_IN);
		#1;
	endtask
	task automatic complete_run;
		$display("Comparisons %0d, mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	// Clock and hang guard
	initial begin
		CORE_CLK_IN = 1'b0;
		forever #20 CORE_CLK_IN = !CORE_CLK_IN;
	end
	always @(posedge CORE_CLK_IN) begin
		cycles++;
		if (SECOND_REV_OUT === 1'b1) phase_seen <= 1'b1;
		if (ANGLE_OUT === 16'h0007) top_seen <= 1'b1;
		if (cycles == 20000) begin
			bad_count++;
			complete_run();
		end
	end
	initial begin
		{RST_N_IN, SCHED_B_GND_IN, REG_WR_IN, REG_RD_IN, eng_run, eng_extra} = '0;
		{REG_ADDR_IN, REG_WDATA_IN} = '0;
		{POT_A_IN, VOLT_IN} = '0;
		POT_B_IN = 12'h800;
		MA_LOOP_IN = `ITC_MA_LOW + 12'h333;
		repeat (3) @(posedge CORE_CLK_IN);
		RST_N_IN <= 1'b1;
		#1;
		`ITC_CHK(SHUTDOWN_OUT, 1'b1)
		rd_chk(`ITC_R_CTRL, `ITC_CTRL_RST);
		rd_chk(`ITC_R_ADV_MAX, `ITC_ADV_RST);
		rd_chk(`ITC_R_RET_MAX, `ITC_RET_RST);
		rd_chk(`ITC_R_TEETH, `ITC_TEETH_RST);
		rd_chk(`ITC_R_SEL_A, `ITC_SEL_RST);
		rd_chk(6'h3f, 16'h0000);
		rd_chk(`ITC_R_STATUS, 16'h0010);
		$display("Test reset values done");
		wr(`ITC_R_KEY, `ITC_KEY_VAL);
		wr(`ITC_R_POTA_CCW, 16'h0050);
		wr(`ITC_R_POTA_CW, 16'h0050);
		rd_chk(`ITC_R_POTA_CCW, 16'h0050);
		wr(`ITC_R_KEY, 16'h0000);
		wr(`ITC_R_POTA_CCW, 16'h0200);
		rd_chk(`ITC_R_POTA_CCW, 16'h0050);
		$display("Test span lock done");
		wr(`ITC_R_SEL_A, 16'h0000);
		tim_chk(16'h0050);
		wr(`ITC_R_KEY, `ITC_KEY_VAL);
		wr(`ITC_R_POTA_CCW, 16'h0300);
		tim_chk(16'h0190);
		wr(`ITC_R_POTA_CCW, 16'hfd00);
		tim_chk(16'hff38);
		wr(`ITC_R_POTA_CCW, 16'h0050);
		wr(`ITC_R_POTB_CCW, 16'h0020);
		wr(`ITC_R_POTB_CW, 16'h0120);
		wr(`ITC_R_SEL_B, 16'h0000);
		@(posedge CORE_CLK_IN) SCHED_B_GND_IN <= 1'b1;
		tim_chk(16'h0050);
		wr(`ITC_R_CTRL, 16'h0003);
		tim_chk(16'h00a0);
		@(posedge CORE_CLK_IN) SCHED_B_GND_IN <= 1'b0;
		tim_chk(16'h0050);
		$display("Test knobs and clamp done");
		wr(`ITC_R_SEL_A, 16'h0001);
		wr(`ITC_R_MA_LO, 16'h0010);
		wr(`ITC_R_MA_HI, 16'h0070);
		tim_chk(16'h0090);
		wr(`ITC_R_MA_DEF, 16'h0030);
		@(posedge CORE_CLK_IN) MA_LOOP_IN <= 12'h000;
		tim_chk(16'h0080);
		wr(`ITC_R_CAN_TIM, 16'h0005);
		wr(`ITC_R_CTRL, 16'h0005);
		tim_chk(16'h0005);
		wr(`ITC_R_CTRL, 16'h0001);
		wr(`ITC_R_SEL_A, 16'h0002);
		wr(`ITC_R_V_LO, 16'h0008);
		tim_chk(16'h0058);
		rd_chk(`ITC_R_TIMING, 16'h0058);
		wr(`ITC_R_SEL_A, 16'h0004);
		wr(`ITC_R_SPD_OF, 16'h0009);
		wr(`ITC_R_SPD_OF + 6'h01, 16'h0011);
		wr(`ITC_R_SPD_OF + 6'h04, 16'h0004);
		rd_chk(`ITC_R_SPD_OF + 6'h01, 16'h0011);
		tim_chk(16'h0054);
		$display("Test offsets done");
		wr(`ITC_R_TEETH, 16'h0008);
		wr(`ITC_R_CTRL, 16'h0009);
		@(posedge CORE_CLK_IN) eng_run <= 1'b1;
		revs(6);
		`ITC_CHK(SHUTDOWN_OUT, 1'b0)
		`ITC_CHK(top_seen, 1'b1)
		`ITC_CHK(phase_seen, 1'b1)
		@(posedge CORE_CLK_IN) eng_extra <= 1'b1;
		revs(2);
		`ITC_CHK(SHUTDOWN_OUT, 1'b1)
		@(posedge CORE_CLK_IN) eng_extra <= 1'b0;
		wr(`ITC_R_CLR_FLT, 16'h0000);
		revs(3);
		`ITC_CHK(SHUTDOWN_OUT, 1'b0)
		$display("Test engine run done");
		complete_run();
	end
endmodule // test_ignition_timing_control
`default_nettype wire
